//--- psf_frontend.sv
// Pixel serializer front end: capture, framing, lanes, power, APB
// Behaviour
// - Bit clock is the system clock, not locked to pixel clock
// - Capture on edge chosen by select
// - Up to three lanes plus forwarded clock
// - Stopped pixel clock gives standby
// - Input order red-green-blue, reversed when enabled
// - Reversal maps colour bus bit n to 23-n
// - Two select inputs choose lane count
// - Shutdown, standby, active power states
// - Select 00/01/10 gives 30/15/10 bits
// - Transmitter off: shutdown, everything released
// - Odd parity over 27 payload bits
// - Standby below 500 kHz, active above 3 MHz
module psf_frontend (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic        PIXEL_CLOCK,
    input  wire logic [23:0] PIXEL_RGB,
    input  wire logic        VERTICAL_SYNC,
    input  wire logic        HORIZONTAL_SYNC,
    input  wire logic        PIXEL_VALID,
    input  wire logic        LATCH_EDGE_SELECT,
    input  wire logic        BUS_REVERSAL,
    input  wire logic        LANE_SELECT_BIT0,
    input  wire logic        LANE_SELECT_BIT1,
    input  wire logic        TRANSMITTER_ON,
    output logic             SERIAL_LANE_0,
    output logic             SERIAL_LANE_0_OE,
    output logic             SERIAL_LANE_1,
    output logic             SERIAL_LANE_1_OE,
    output logic             SERIAL_LANE_2,
    output logic             SERIAL_LANE_2_OE,
    output logic             SERIAL_CLOCK_LANE,
    output logic             SERIAL_CLOCK_LANE_OE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic                     pclk_s1;
        logic                     pclk_s2;
        logic                     pclk_s3;
        logic [26:0]              din_s1;
        logic [26:0]              din_s2;
        logic [4:0]               ctl_s1;
        logic [4:0]               ctl_s2;
        psf_pkg::psf_power_e      power;
        logic [psf_pkg::GAP_W-1:0] gap;
        logic [29:0]              shreg;
        logic [4:0]               bit_cnt;
        logic [4:0]               bits;
        logic                     busy;
        logic                     cap_en;
        logic                     ovf;
        logic [31:0]              frames;
        logic [29:0]              last_frame;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
        logic [2:0]               lane;
        logic [2:0]               lane_oe;
        logic                     clk_out;
        logic                     clk_oe;
    } psf_state_s;

    psf_state_s r_reg;
    psf_state_s r_next;

    psf_stream_if #(.WIDTH(psf_pkg::FRAME_W)) fifo_st ();

    psf_fifo #(
        .WIDTH (psf_pkg::FRAME_W),
        .DEPTH (psf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .SYS_CLK (SYS_CLK),
        .RST_B   (RST_B),
        .st      (fifo_st)
    );

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Bits per lane for a lane mode, zero when reserved
    function automatic logic [4:0] bits_per_lane(input logic [1:0] mode);
        case (mode)
            psf_pkg::MODE_ONE_LANE:   bits_per_lane = psf_pkg::BITS_ONE_LANE;
            psf_pkg::MODE_TWO_LANE:   bits_per_lane = psf_pkg::BITS_TWO_LANE;
            psf_pkg::MODE_THREE_LANE: bits_per_lane = psf_pkg::BITS_THREE_LANE;
            default:                  bits_per_lane = 5'h00;
        endcase
    endfunction

    // Whole colour bus reversed end for end
    function automatic logic [23:0] reverse24(input logic [23:0] v);
        logic [23:0] o;
        o = '0;
        for (int i = 0; i < 24; i++) begin
            o[i] = v[23-i];
        end
        return o;
    endfunction

    // Register address match
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
        return (a == ref_a);
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic        rise;
    logic        fall;
    logic        cap_edge;
    logic        txon;
    logic [1:0]  mode;
    logic [4:0]  bpl;
    logic [23:0] rgb;
    logic [29:0] frame;
    logic        load;
    logic        setup;
    logic        wr_acc;
    logic        mapped;
    logic [31:0] rd_val;

    assign fifo_st.wr_valid = cap_edge && (r_reg.power == psf_pkg::PSF_ACTIVE) && r_reg.cap_en;
    assign fifo_st.wr_data  = frame;
    assign fifo_st.rd_ready = load;
    assign fifo_st.flush    = (r_reg.power != psf_pkg::PSF_ACTIVE);

    always_comb begin
        r_next   = r_reg;
        // Input synchronisers
        r_next.pclk_s1 = PIXEL_CLOCK;
        r_next.pclk_s2 = r_reg.pclk_s1;
        r_next.pclk_s3 = r_reg.pclk_s2;
        r_next.din_s1  = {PIXEL_RGB, VERTICAL_SYNC, HORIZONTAL_SYNC, PIXEL_VALID};
        r_next.din_s2  = r_reg.din_s1;
        r_next.ctl_s1  = {TRANSMITTER_ON, LANE_SELECT_BIT1, LANE_SELECT_BIT0,
                          BUS_REVERSAL, LATCH_EDGE_SELECT};
        r_next.ctl_s2  = r_reg.ctl_s1;

        rise     = r_reg.pclk_s2 && !r_reg.pclk_s3;
        fall     = !r_reg.pclk_s2 && r_reg.pclk_s3;
        cap_edge = r_reg.ctl_s2[0] ? fall : rise;
        txon     = r_reg.ctl_s2[4];
        mode     = r_reg.ctl_s2[3:2];
        bpl      = bits_per_lane(mode);

        // Frame assembly from the captured word
        rgb = r_reg.ctl_s2[1] ? reverse24(r_reg.din_s2[26:3])
                              : r_reg.din_s2[26:3];
        frame = '0;
        frame[psf_pkg::FRM_RGB_LSB +: psf_pkg::RGB_W] = rgb;
        frame[psf_pkg::FRM_VS_POS]    = r_reg.din_s2[2];
        frame[psf_pkg::FRM_HS_POS]    = r_reg.din_s2[1];
        frame[psf_pkg::FRM_VALID_POS] = r_reg.din_s2[0];
        frame[psf_pkg::FRM_PAR_POS]   = ~(^frame[psf_pkg::FRM_VALID_POS +: psf_pkg::PAYLOAD_W]);
        frame[psf_pkg::FRM_RSV_LSB +: 2] = psf_pkg::FRM_RSV_VALUE;

        // Power state and pixel clock monitor
        if (!txon) begin
            r_next.power = psf_pkg::PSF_SHUTDOWN;
            r_next.gap   = '0;
        end else if (rise) begin
            r_next.gap = '0;
            if (r_reg.gap < psf_pkg::GAP_W'(psf_pkg::ACTIVE_CYC)) begin
                r_next.power = psf_pkg::PSF_ACTIVE;
            end else if (r_reg.power == psf_pkg::PSF_SHUTDOWN) begin
                r_next.power = psf_pkg::PSF_STANDBY;
            end
        end else begin
            if (r_reg.gap < psf_pkg::GAP_W'(psf_pkg::STANDBY_CYC)) begin
                r_next.gap = r_reg.gap + 1'b1;
            end else begin
                r_next.power = psf_pkg::PSF_STANDBY;
            end
            if (r_reg.power == psf_pkg::PSF_SHUTDOWN) begin
                r_next.power = psf_pkg::PSF_STANDBY;
            end
        end

        // Capture bookkeeping; overflow set wins over clear
        if (fifo_st.wr_valid) begin
            r_next.last_frame = frame;
        end

        // Serializer: one bit per lane each cycle
        load = 1'b0;
        if (r_reg.power != psf_pkg::PSF_ACTIVE || bpl == 5'h00) begin
            r_next.busy    = 1'b0;
            r_next.bit_cnt = '0;
        end else if (r_reg.busy && r_reg.bit_cnt != r_reg.bits - 5'h01) begin
            r_next.shreg   = {r_reg.shreg[28:0], 1'b0};
            r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
        end else begin
            load = fifo_st.rd_valid;
            r_next.busy    = fifo_st.rd_valid;
            r_next.shreg   = fifo_st.rd_data;
            r_next.bit_cnt = '0;
            r_next.bits    = bpl;
            if (fifo_st.rd_valid) begin
                r_next.frames = r_reg.frames + 32'h0000_0001;
            end
        end

        // Lane taps: lane i carries its slice of the frame MSB first
        for (int i = 0; i < 3; i++) begin
            r_next.lane[i] = r_next.busy && (i <= int'(mode)) &&
                             r_next.shreg[29 - i * int'(r_next.bits)];
            r_next.lane_oe[i] = (r_next.power == psf_pkg::PSF_ACTIVE) &&
                                (bpl != 5'h00) && (i <= int'(mode));
        end
        // Forwarded clock is the bit clock divided by bits per lane
        r_next.clk_out = r_next.busy && (r_next.bit_cnt < (r_next.bits >> 1));
        r_next.clk_oe  = (r_next.power == psf_pkg::PSF_ACTIVE);

        // APB slave, zero wait: answer registered in the setup cycle
        setup  = PSEL && !PENABLE;
        wr_acc = PSEL && PENABLE && r_reg.pready && PWRITE;
        mapped = addr_is(PADDR, psf_pkg::ADDR_CTRL) || addr_is(PADDR, psf_pkg::ADDR_STATUS) ||
                 addr_is(PADDR, psf_pkg::ADDR_FRAMES) || addr_is(PADDR, psf_pkg::ADDR_LAST);
        rd_val = '0;
        if (addr_is(PADDR, psf_pkg::ADDR_CTRL)) begin
            rd_val[psf_pkg::CTRL_CAP_EN_POS] = r_reg.cap_en;
        end else if (addr_is(PADDR, psf_pkg::ADDR_STATUS)) begin
            rd_val[psf_pkg::ST_POWER_LSB +: 2] = r_reg.power;
            rd_val[psf_pkg::ST_MODE_LSB +: 2]  = mode;
            rd_val[psf_pkg::ST_OVF_POS]        = r_reg.ovf;
            rd_val[psf_pkg::ST_EMPTY_POS]      = fifo_st.empty;
            rd_val[psf_pkg::ST_BUSY_POS]       = r_reg.busy;
        end else if (addr_is(PADDR, psf_pkg::ADDR_FRAMES)) begin
            rd_val = r_reg.frames;
        end else if (addr_is(PADDR, psf_pkg::ADDR_LAST)) begin
            rd_val[29:0] = r_reg.last_frame;
        end
        r_next.pready  = setup;
        r_next.pslverr = setup && !mapped;
        r_next.prdata  = (setup && !PWRITE) ? rd_val : 32'h0000_0000;

        // Register writes at the access edge
        if (wr_acc && addr_is(PADDR, psf_pkg::ADDR_CTRL)) begin
            r_next.cap_en = PWDATA[psf_pkg::CTRL_CAP_EN_POS];
        end
        if (wr_acc && addr_is(PADDR, psf_pkg::ADDR_STATUS) && PWDATA[psf_pkg::ST_OVF_POS]) begin
            r_next.ovf = 1'b0;
        end
        if (fifo_st.wr_valid && !fifo_st.wr_ready) begin
            r_next.ovf = 1'b1;
        end
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            r_reg        <= '0;
            r_reg.cap_en <= psf_pkg::CTRL_RESET[psf_pkg::CTRL_CAP_EN_POS];
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register
    assign SERIAL_LANE_0        = r_reg.lane[0];
    assign SERIAL_LANE_0_OE     = r_reg.lane_oe[0];
    assign SERIAL_LANE_1        = r_reg.lane[1];
    assign SERIAL_LANE_1_OE     = r_reg.lane_oe[1];
    assign SERIAL_LANE_2        = r_reg.lane[2];
    assign SERIAL_LANE_2_OE     = r_reg.lane_oe[2];
    assign SERIAL_CLOCK_LANE    = r_reg.clk_out;
    assign SERIAL_CLOCK_LANE_OE = r_reg.clk_oe;
    assign PRDATA               = r_reg.prdata;
    assign PREADY               = r_reg.pready;
    assign PSLVERR              = r_reg.pslverr;

endmodule // psf_frontend

//--- psf_pkg.sv
// Constants and types shared by the pixel serializer front end
package psf_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SYS_CLK_PERIOD_PS = 20000;
    localparam int STANDBY_PERIOD_PS = 2000000;   // Clock below 500 kHz
    localparam int ACTIVE_PERIOD_PS  = 333333;    // Clock above 3 MHz
    // Least time: round up
    localparam int STANDBY_CYC = (STANDBY_PERIOD_PS + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
    // Longest time: round down
    localparam int ACTIVE_CYC  = ACTIVE_PERIOD_PS / SYS_CLK_PERIOD_PS;
    localparam int GAP_W       = 7;

    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam int FRAME_W      = 30;
    localparam int PAYLOAD_W    = 27;
    localparam int RGB_W        = 24;
    localparam int FRM_RGB_LSB  = 6;
    localparam int FRM_VS_POS   = 5;
    localparam int FRM_HS_POS   = 4;
    localparam int FRM_VALID_POS = 3;
    localparam int FRM_PAR_POS  = 2;
    localparam int FRM_RSV_LSB  = 0;
    localparam logic [1:0] FRM_RSV_VALUE = 2'h0;
    localparam int FIFO_DEPTH   = 8;

    // ****************************************************************
    // Lane modes
    // ****************************************************************
    localparam logic [1:0] MODE_ONE_LANE   = 2'h0;
    localparam logic [1:0] MODE_TWO_LANE   = 2'h1;
    localparam logic [1:0] MODE_THREE_LANE = 2'h2;
    localparam logic [4:0] BITS_ONE_LANE   = 5'h1E;
    localparam logic [4:0] BITS_TWO_LANE   = 5'h0F;
    localparam logic [4:0] BITS_THREE_LANE = 5'h0A;

    // ****************************************************************
    // Registers
    // ****************************************************************
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_FRAMES = 8'h08;
    localparam logic [7:0]  ADDR_LAST   = 8'h0C;
    localparam int          CTRL_CAP_EN_POS = 0;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
    localparam int          ST_POWER_LSB = 0;
    localparam int          ST_MODE_LSB  = 2;
    localparam int          ST_OVF_POS   = 4;
    localparam int          ST_EMPTY_POS = 5;
    localparam int          ST_BUSY_POS  = 6;

    typedef enum logic [1:0] {
        PSF_SHUTDOWN = 2'b00,
        PSF_STANDBY  = 2'b01,
        PSF_ACTIVE   = 2'b10
    } psf_power_e;

endpackage : psf_pkg

//--- psf_stream_if.sv
// Stream interface between the front end and its frame FIFO
interface psf_stream_if #(parameter int WIDTH = 30);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;
    logic             flush;
    logic             empty;

    modport fifo (input wr_valid, wr_data, rd_ready, flush,
                  output wr_ready, rd_valid, rd_data, empty);
    modport user (output wr_valid, wr_data, rd_ready, flush,
                  input wr_ready, rd_valid, rd_data, empty);
endinterface : psf_stream_if

//--- psf_fifo.sv
// Frame FIFO with valid and ready on both sides
module psf_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 8
) (
    input  wire logic   SYS_CLK,
    input  wire logic   RST_B,
    psf_stream_if.fifo  st
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0]                 wptr;
        logic [PW:0]                 rptr;
    } psf_fifo_s;

    psf_fifo_s r_reg;
    psf_fifo_s r_next;
    logic      full;
    logic      empty;

    // Full when pointers differ only in the wrap bit
    assign full  = (r_reg.wptr[PW] != r_reg.rptr[PW]) &&
                   (r_reg.wptr[PW-1:0] == r_reg.rptr[PW-1:0]);
    assign empty = (r_reg.wptr == r_reg.rptr);
    assign st.wr_ready = !full;
    assign st.rd_valid = !empty;
    assign st.rd_data  = r_reg.mem[r_reg.rptr[PW-1:0]];
    assign st.empty    = empty;

    // Pointer and storage update
    always_comb begin
        r_next = r_reg;
        if (st.flush) begin
            r_next.wptr = '0;
            r_next.rptr = '0;
        end else begin
            if (st.wr_valid && !full) begin
                r_next.mem[r_reg.wptr[PW-1:0]] = st.wr_data;
                r_next.wptr = r_reg.wptr + 1'b1;
            end
            if (st.rd_ready && !empty) begin
                r_next.rptr = r_reg.rptr + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

endmodule // psf_fifo

//--- psf_frontend_asserts.sv
// Port checker for the pixel serializer front end
module psf_frontend_asserts (
    input wire logic        SYS_CLK,
    input wire logic        RST_B,
    input wire logic        PIXEL_CLOCK,
    input wire logic        LANE_SELECT_BIT0,
    input wire logic        LANE_SELECT_BIT1,
    input wire logic        TRANSMITTER_ON,
    input wire logic        SERIAL_LANE_2,
    input wire logic        SERIAL_LANE_0_OE,
    input wire logic        SERIAL_LANE_1_OE,
    input wire logic        SERIAL_LANE_2_OE,
    input wire logic        SERIAL_CLOCK_LANE,
    input wire logic        SERIAL_CLOCK_LANE_OE,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    logic [7:0] still_cnt;
    logic       pclk_d;

    // Cycles since the pixel clock last moved
    always_ff @(posedge SYS_CLK) begin
        pclk_d <= PIXEL_CLOCK;
        if (!RST_B || PIXEL_CLOCK != pclk_d) begin
            still_cnt <= 8'h00;
        end else if (still_cnt != 8'hFF) begin
            still_cnt <= still_cnt + 8'h01;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready in access cycle");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    apb_refuse_a: assert property (PSEL && !PENABLE && PADDR > 8'h0C
        |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    lane0_mode_a: assert property (SERIAL_LANE_0_OE |-> !(LANE_SELECT_BIT0 && LANE_SELECT_BIT1))
        else $error("lane 0 driven in reserved mode");
    lane1_mode_a: assert property (SERIAL_LANE_1_OE |-> LANE_SELECT_BIT0 ^ LANE_SELECT_BIT1)
        else $error("lane 1 driven in one lane mode");
    lane2_mode_a: assert property (SERIAL_LANE_2_OE |-> LANE_SELECT_BIT1 && !LANE_SELECT_BIT0)
        else $error("lane 2 driven outside three lane mode");
    off_release_a: assert property (!TRANSMITTER_ON [*6]
        |-> !SERIAL_CLOCK_LANE_OE && !SERIAL_LANE_0_OE)
        else $error("outputs driven while transmitter off");
    stop_standby_a: assert property (still_cnt > 8'h78 |-> !SERIAL_CLOCK_LANE_OE)
        else $error("clock lane driven with pixel clock stopped");
    clock_shape_a: assert property ($rose(SERIAL_CLOCK_LANE) && SERIAL_LANE_2_OE
        |-> SERIAL_CLOCK_LANE [*5] ##1 !SERIAL_CLOCK_LANE)
        else $error("forwarded clock shape wrong");
    reserved_zero_a: assert property ($rose(SERIAL_CLOCK_LANE) && SERIAL_LANE_2_OE
        |-> ##8 !SERIAL_LANE_2 ##1 !SERIAL_LANE_2)
        else $error("reserved frame bits not zero");
endmodule // psf_frontend_asserts

bind psf_frontend psf_frontend_asserts psf_frontend_asserts_inst (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .PIXEL_CLOCK(PIXEL_CLOCK),
    .LANE_SELECT_BIT0(LANE_SELECT_BIT0), .LANE_SELECT_BIT1(LANE_SELECT_BIT1),
    .TRANSMITTER_ON(TRANSMITTER_ON), .SERIAL_LANE_2(SERIAL_LANE_2),
    .SERIAL_LANE_0_OE(SERIAL_LANE_0_OE), .SERIAL_LANE_1_OE(SERIAL_LANE_1_OE),
    .SERIAL_LANE_2_OE(SERIAL_LANE_2_OE), .SERIAL_CLOCK_LANE(SERIAL_CLOCK_LANE),
    .SERIAL_CLOCK_LANE_OE(SERIAL_CLOCK_LANE_OE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

//--- psf_host_model.sv
// Host display controller model: pixel clock and parallel word
module psf_host_model (
    input  wire logic        run,
    input  wire logic        edge_sel,
    input  wire logic [26:0] word,
    output logic             pixel_clock,
    output logic [26:0]      pixel_bus
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pixel_clock = 1'b0;
    initial pixel_bus = 27'h0;

    // Pixel clock of 160 ns, standing low while not running
    always begin
        #80;
        pixel_clock = run ? ~pixel_clock : 1'b0;
    end

    // New word on the edge opposite the capture edge
    always @(pixel_clock) begin
        if (pixel_clock == edge_sel) begin
            pixel_bus <= word;
        end
    end
endmodule // psf_host_model

//--- testbench.sv
// Self-checking testbench of the pixel serializer front end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        run = 1'b0;
    logic        edge_sel = 1'b0;
    logic        rev = 1'b0;
    logic [1:0]  ls = 2'h0;
    logic        tx_on = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [26:0] word = 27'h0;
    logic        pclk;
    logic [26:0] pbus;
    logic [2:0]  lane;
    logic [2:0]  lane_oe;
    logic        clk_lane;
    logic        clk_oe;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          errors = 0;
    int          comparisons = 0;

    // ****************************************************************
    // Clock, partner and design
    // ****************************************************************
    always #10 sys_clk = ~sys_clk;

    psf_host_model psf_host_model_inst (.run(run), .edge_sel(edge_sel), .word(word),
        .pixel_clock(pclk), .pixel_bus(pbus));

    psf_frontend psf_frontend_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .PIXEL_CLOCK(pclk),
        .PIXEL_RGB(pbus[26:3]), .VERTICAL_SYNC(pbus[2]), .HORIZONTAL_SYNC(pbus[1]),
        .PIXEL_VALID(pbus[0]), .LATCH_EDGE_SELECT(edge_sel), .BUS_REVERSAL(rev),
        .LANE_SELECT_BIT0(ls[0]), .LANE_SELECT_BIT1(ls[1]), .TRANSMITTER_ON(tx_on),
        .SERIAL_LANE_0(lane[0]), .SERIAL_LANE_0_OE(lane_oe[0]), .SERIAL_LANE_1(lane[1]),
        .SERIAL_LANE_1_OE(lane_oe[1]), .SERIAL_LANE_2(lane[2]), .SERIAL_LANE_2_OE(lane_oe[2]),
        .SERIAL_CLOCK_LANE(clk_lane), .SERIAL_CLOCK_LANE_OE(clk_oe), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        // Request stands until ready is seen at a rising edge
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic status(output logic [31:0] s);
        logic e;
        apb(1'b0, psf_pkg::ADDR_STATUS, 32'h0, s, e);
    endtask

    function automatic logic [29:0] exp_frame(input logic [26:0] w, input logic r);
        logic [26:0] p;
        p = w;
        for (int i = 0; i < 24; i++) if (r) p[3+i] = w[26-i];
        return {p, ~^p, 2'h0};
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        logic [31:0] d;
        logic        e;
        check("oe after reset", {lane_oe, clk_oe}, 4'h0);
        apb(1'b0, psf_pkg::ADDR_CTRL, 32'h0, d, e);
        check("ctrl reset", d, psf_pkg::CTRL_RESET);
        status(d);
        check("power off", d[1:0], 2'h0);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF, d, e);
        check("unmapped write err", e, 1'b1);
        apb(1'b0, 8'h10, 32'h0, d, e);
        check("unmapped read", d, 32'h0);
        check("unmapped read err", e, 1'b1);
    endtask

    task automatic t_lanes(input logic [1:0] m, input logic [26:0] w);
        logic [31:0] s;
        logic [29:0] got;
        logic        e;
        logic        prev;
        int          bits;
        int          highs;
        int          n;
        int          idx;
        run <= 1'b0;
        tx_on <= 1'b0;
        repeat (10) @(posedge sys_clk);
        ls <= m;
        rev <= m[1];
        edge_sel <= m[0];
        word <= w;
        @(posedge sys_clk);
        tx_on <= 1'b1;
        repeat (6) @(posedge sys_clk);
        status(s);
        check("standby", s[3:0], {m, 2'h1});
        run <= 1'b1;
        n = 0;
        do begin
            status(s);
            n++;
        end while (s[1:0] !== 2'h2 && n < 30);
        check("active", s[1:0], 2'h2);
        if (m == 2'h3) begin
            repeat (100) @(posedge sys_clk);
            check("reserved mode oe", {lane_oe, clk_oe}, 4'h1);
            check("reserved mode idle", {lane, clk_lane}, 4'h0);
            return;
        end
        bits = (m == 2'h0) ? 30 : (m == 2'h1) ? 15 : 10;
        prev = 1'b1;
        n = 0;
        @(posedge sys_clk);
        #1;
        while (!(clk_lane === 1'b1 && prev === 1'b0) && n < 300) begin
            prev = clk_lane;
            @(posedge sys_clk);
            #1;
            n++;
        end
        got = 30'h0;
        highs = 0;
        check("lane oe", lane_oe, (m == 2'h0) ? 3'h1 : (m == 2'h1) ? 3'h3 : 3'h7);
        for (int k = 0; k < bits; k++) begin
            for (int l = 0; l < 3; l++) begin
                idx = 29 - l * bits - k;
                if (idx >= 0) got[idx] = lane[l];
            end
            highs += (clk_lane === 1'b1);
            @(posedge sys_clk);
            #1;
        end
        check("frame", got, exp_frame(w, m[1]));
        check("clock high", highs, bits / 2);
        apb(1'b0, psf_pkg::ADDR_LAST, 32'h0, s, e);
        check("last", s, {2'h0, exp_frame(w, m[1])});
    endtask

    task automatic t_standby();
        logic [31:0] s;
        logic        e;
        run <= 1'b0;
        repeat (150) @(posedge sys_clk);
        status(s);
        check("standby power", s[1:0], 2'h1);
        check("flushed, overflow", s[5:4], 2'h3);
        check("standby oe", {lane_oe, clk_oe}, 4'h0);
        apb(1'b1, psf_pkg::ADDR_STATUS, 32'h0000_0010, s, e);
        status(s);
        check("overflow cleared", s[4], 1'b0);
        tx_on <= 1'b0;
        repeat (8) @(posedge sys_clk);
        status(s);
        check("shutdown power", s[1:0], 2'h0);
        check("shutdown oe", {lane_oe, clk_oe}, 4'h0);
    endtask

    // ****************************************************************
    // Run control
    // ****************************************************************
    task automatic give_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #1000000;
        errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_lanes(2'h0, 27'h2B4C1E5);
        t_lanes(2'h1, 27'h13579BD);
        t_lanes(2'h2, 27'h7E81A3C);
        t_lanes(2'h3, 27'h0F0F0F1);
        t_standby();
        give_verdict();
    end
endmodule // testbench
